// ### design/rxevm_pkg.sv
package rxevm_pkg;

   // Sample and field layout
   localparam int unsigned EVM_W         = 16;
   localparam int unsigned SUM_W         = 20;
   localparam int unsigned PEAK_INT_MSB  = 15;
   localparam int unsigned PEAK_INT_LSB  = 9;
   localparam int unsigned PEAK_FRAC_MSB = 8;
   localparam int unsigned SUM_WORD_LSB  = 12;
   localparam int unsigned HDR_SYMBOLS   = 2;
   localparam int unsigned ADDR_W        = 18;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_HDR_PEAK = 16'hFE3B;
   localparam logic [15:0] IDX_PAY_PEAK = 16'hFE3D;
   localparam logic [15:0] IDX_HDR_SUM  = 16'hFE3F;
   localparam logic [15:0] IDX_PAY_SUM  = 16'hFE43;
   localparam logic [15:0] IDX_CTRL     = 16'hFE47;
   localparam logic [15:0] IDX_STATUS   = 16'hFE48;
   localparam logic [15:0] IDX_PAY_CNT  = 16'hFE49;

   // Reset values
   localparam logic [EVM_W-1:0] PEAK_RST = 16'h0000;
   localparam logic [SUM_W-1:0] SUM_RST  = 20'h00000;
   localparam logic [1:0]       CTRL_RST = 2'h1;
   localparam logic [15:0]      CNT_RST  = 16'h0000;

   // Control and status fields
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_CLR_BIT  = 1;
   localparam int unsigned STAT_ST_LSB   = 0;
   localparam int unsigned STAT_HCNT_LSB = 4;

   // Receive phase, one-hot
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_HEADER  = 3'b010,
      ST_PAYLOAD = 3'b100
   } rxevm_state_e;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction

endpackage

// ### design/rxevm_max_hold.sv
`timescale 1ns/1ps
`default_nettype none

module rxevm_max_hold #(
   parameter int unsigned W = 16
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         clear,
   input  wire logic         sampleValid,
   input  wire logic [W-1:0] sample,
   output logic      [W-1:0] maxValue
);

   logic [W-1:0] next_maxValue;
   logic         bigger;

   // Clear has priority so a new message never inherits an old peak
   assign bigger        = sampleValid && (sample > maxValue);
   assign next_maxValue = clear ? '0 : (bigger ? sample : maxValue);

   // Running maximum
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         maxValue <= '0;
      end else begin
         maxValue <= next_maxValue;
      end
   end

endmodule

`default_nettype wire

// ### design/rxevm_symbol_sum.sv
`timescale 1ns/1ps
`default_nettype none

module rxevm_symbol_sum #(
   parameter int unsigned IN_W  = 16,
   parameter int unsigned SUM_W = 20
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             clear,
   input  wire logic             addValid,
   input  wire logic [IN_W-1:0]  addValue,
   input  wire logic             symbolEnd,
   output logic      [SUM_W-1:0] symSum
);

   logic [SUM_W-1:0] acc;
   logic [SUM_W:0]   wide;
   logic [SUM_W-1:0] next_acc;

   // Sum saturates rather than wraps, so an overflow still reads as a large error
   assign wide     = {1'b0, acc} + (addValid ? (SUM_W+1)'(addValue) : '0);
   assign symSum   = wide[SUM_W] ? '1 : wide[SUM_W-1:0];
   assign next_acc = (clear || symbolEnd) ? '0 : symSum;

   // Accumulator restarts after each symbol boundary
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         acc <= '0;
      end else begin
         acc <= next_acc;
      end
   end

endmodule

`default_nettype wire

// ### design/rxevm_stats.sv
`timescale 1ns/1ps
`default_nettype none

module rxevm_stats #(
   parameter int unsigned EVM_W  = rxevm_pkg::EVM_W,
   parameter int unsigned SUM_W  = rxevm_pkg::SUM_W,
   parameter int unsigned ADDR_W = rxevm_pkg::ADDR_W
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Demodulator side, same clock
   input  wire logic              rxStart,
   input  wire logic              rxEnd,
   input  wire logic              carrierValid,
   input  wire logic [EVM_W-1:0]  carrierEvm,
   input  wire logic              symbolEnd
);

   rxevm_pkg::rxevm_state_e state;
   rxevm_pkg::rxevm_state_e next_state;

   logic [1:0]             ctrl;
   logic [1:0]             hdrCount;
   logic [1:0]             next_hdrCount;
   logic [15:0]            payCount;
   logic [15:0]            next_payCount;
   logic [1:0]             segActive;
   logic [1:0][EVM_W-1:0]  peakVal;
   logic [1:0][SUM_W-1:0]  sumVal;
   logic [SUM_W-1:0]       symSum;
   logic                   capture;
   logic                   softClear;
   logic                   msgClear;
   logic                   lastHdrSymbol;

   logic                   setupPhase;
   logic                   accessPhase;
   logic                   wrAccess;
   logic                   selHdrPeak;
   logic                   selPayPeak;
   logic                   selHdrSum;
   logic                   selPaySum;
   logic                   selCtrl;
   logic                   selStatus;
   logic                   selPayCnt;
   logic                   mapped;
   logic [31:0]            rdMux;
   logic [31:0]            statusWord;
   logic [31:0]            next_prdata;
   logic                   next_pslverr;
   logic [1:0]             next_ctrl;

   // APB phase decode; the slave never inserts wait states
   assign setupPhase  = psel && !penable;
   assign accessPhase = psel && penable;
   assign pready      = accessPhase;
   assign wrAccess    = accessPhase && pwrite;

   // Address decode against byte addresses of the register indices
   assign selHdrPeak = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_HDR_PEAK));
   assign selPayPeak = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_PAY_PEAK));
   assign selHdrSum  = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_HDR_SUM));
   assign selPaySum  = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_PAY_SUM));
   assign selCtrl    = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_CTRL));
   assign selStatus  = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_STATUS));
   assign selPayCnt  = (paddr == rxevm_pkg::reg_addr(rxevm_pkg::IDX_PAY_CNT));
   assign mapped     = selHdrPeak || selPayPeak || selHdrSum || selPaySum
                       || selCtrl || selStatus || selPayCnt;

   // Control: capture enable steers the trackers, clear is a write-one pulse
   assign softClear = wrAccess && selCtrl && pstrb[0]
                      && pwdata[rxevm_pkg::CTRL_CLR_BIT];
   assign next_ctrl = (wrAccess && selCtrl && pstrb[0])
                      ? {1'b0, pwdata[rxevm_pkg::CTRL_EN_BIT]} : ctrl;
   assign capture   = ctrl[rxevm_pkg::CTRL_EN_BIT];

   assign msgClear = rxStart || softClear;

   // Header ends after its fixed number of symbols
   assign lastHdrSymbol = (state == rxevm_pkg::ST_HEADER) && symbolEnd
                          && (hdrCount == 2'(rxevm_pkg::HDR_SYMBOLS - 1));

   // Receive phase sequencing; a new start always restarts the header
   always_comb begin
      next_state = state;
      case (state)
         rxevm_pkg::ST_IDLE: begin
            if (rxStart) begin
               next_state = rxevm_pkg::ST_HEADER;
            end
         end
         rxevm_pkg::ST_HEADER: begin
            if (rxStart) begin
               next_state = rxevm_pkg::ST_HEADER;
            end else if (rxEnd) begin
               next_state = rxevm_pkg::ST_IDLE;
            end else if (lastHdrSymbol) begin
               next_state = rxevm_pkg::ST_PAYLOAD;
            end
         end
         rxevm_pkg::ST_PAYLOAD: begin
            if (rxStart) begin
               next_state = rxevm_pkg::ST_HEADER;
            end else if (rxEnd) begin
               next_state = rxevm_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = rxevm_pkg::ST_IDLE;
         end
      endcase
   end

   // Segment select for the trackers
   assign segActive[0] = (state == rxevm_pkg::ST_HEADER);
   assign segActive[1] = (state == rxevm_pkg::ST_PAYLOAD);

   // Symbol counters; payload count saturates instead of wrapping
   assign next_hdrCount = rxStart ? 2'h0
                          : ((segActive[0] && symbolEnd) ? hdrCount + 2'h1 : hdrCount);
   assign next_payCount = msgClear ? rxevm_pkg::CNT_RST
                          : ((segActive[1] && symbolEnd && (payCount != 16'hFFFF))
                             ? payCount + 16'h0001 : payCount);

   // Phase, control and counters
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state    <= rxevm_pkg::ST_IDLE;
         ctrl     <= rxevm_pkg::CTRL_RST;
         hdrCount <= 2'h0;
         payCount <= rxevm_pkg::CNT_RST;
      end else begin
         state    <= next_state;
         ctrl     <= next_ctrl;
         hdrCount <= next_hdrCount;
         payCount <= next_payCount;
      end
   end

   rxevm_symbol_sum #(
      .IN_W  (EVM_W),
      .SUM_W (SUM_W)
   ) u_symbol_sum (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .clear     (rxStart),
      .addValid  (carrierValid),
      .addValue  (carrierEvm),
      .symbolEnd (symbolEnd),
      .symSum    (symSum)
   );

   // One peak and one symbol-sum tracker for header and for payload
   genvar seg;
   generate
      for (seg = 0; seg < 2; seg++) begin : g_seg
         rxevm_max_hold #(
            .W (EVM_W)
         ) u_peak (
            .core_clk    (core_clk),
            .nrst        (nrst),
            .clear       (msgClear),
            .sampleValid (capture && carrierValid && segActive[seg]),
            .sample      (carrierEvm),
            .maxValue    (peakVal[seg])
         );
         rxevm_max_hold #(
            .W (SUM_W)
         ) u_sum (
            .core_clk    (core_clk),
            .nrst        (nrst),
            .clear       (msgClear),
            .sampleValid (capture && symbolEnd && segActive[seg]),
            .sample      (symSum),
            .maxValue    (sumVal[seg])
         );
      end
   endgenerate

   // Status shows the receive phase and header symbols seen
   assign statusWord = {26'h0000000, hdrCount, 1'b0, state};

   // Read mux
   always_comb begin
      rdMux = 32'h00000000;
      if (selHdrPeak) begin
         rdMux = {16'h0000, peakVal[0]};
      end else if (selPayPeak) begin
         rdMux = {16'h0000, peakVal[1]};
      end else if (selHdrSum) begin
         rdMux = {sumVal[0], 12'h000};
      end else if (selPaySum) begin
         rdMux = {sumVal[1], 12'h000};
      end else if (selCtrl) begin
         rdMux = {30'h00000000, ctrl};
      end else if (selStatus) begin
         rdMux = statusWord;
      end else if (selPayCnt) begin
         rdMux = {16'h0000, payCount};
      end
   end

   // Read data and error are captured in the setup phase, so they are stable
   // for the whole access phase; writes to read-only words are ignored
   assign next_prdata  = (setupPhase && !pwrite) ? rdMux : prdata;
   assign next_pslverr = setupPhase ? !mapped : pslverr;

   // Bus answer registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

endmodule

`default_nettype wire

// ### tb/rxevm_stats_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rxevm_stats_asserts #(
   parameter int unsigned EVM_W  = 16,
   parameter int unsigned SUM_W  = 20,
   parameter int unsigned ADDR_W = 18
) (
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              rxStart,
   input wire logic              rxEnd,
   input wire logic              carrierValid,
   input wire logic [EVM_W-1:0]  carrierEvm,
   input wire logic              symbolEnd
);
   // Address decode of the four statistics words
   wire logic rdSet  = psel && !penable && !pwrite;
   wire logic isHp   = paddr == {rxevm_pkg::IDX_HDR_PEAK, 2'b00};
   wire logic isPs   = paddr == {rxevm_pkg::IDX_PAY_SUM, 2'b00};
   wire logic isPeak = isHp || paddr == {rxevm_pkg::IDX_PAY_PEAK, 2'b00};
   wire logic isSum  = isPs || paddr == {rxevm_pkg::IDX_HDR_SUM, 2'b00};

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Read data is a setup snapshot, so checks look one cycle on
   property p_peak_up; rdSet && isPeak |=> prdata[31:16] == 16'h0000; endproperty
   a_peak_up: assert property (p_peak_up) else $error("peak upper half set");
   property p_sum_lo; rdSet && isSum |=> prdata[11:0] == 12'h000; endproperty
   a_sum_lo: assert property (p_sum_lo) else $error("sum low bits set");
   property p_ro_wr; psel && !penable && pwrite && (isPeak || isSum) |=> !pslverr; endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("write to stat word errored");
   property p_mapped; rdSet && (isPeak || isSum) |=> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("stat read errored");
   property p_ready; pready == (psel && penable); endproperty
   a_ready: assert property (p_ready) else $error("pready wrong");
   property p_hold; psel && penable && !pwrite |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_clr_pk; $past(rxStart) && rdSet && isHp |=> prdata == 32'h0; endproperty
   a_clr_pk: assert property (p_clr_pk) else $error("peak kept over start");
   property p_clr_sum; $past(rxStart) && rdSet && isPs |=> prdata == 32'h0; endproperty
   a_clr_sum: assert property (p_clr_sum) else $error("sum kept over start");

   // Main scenarios reached
   c_start_rd: cover property (rxStart ##1 rdSet);
   c_sym_end: cover property (carrierValid && symbolEnd);
   c_msg_end: cover property (rxEnd);
endmodule

bind rxevm_stats rxevm_stats_asserts #(.EVM_W(EVM_W), .SUM_W(SUM_W), .ADDR_W(ADDR_W)) u_chk (
   .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxStart(rxStart), .rxEnd(rxEnd), .carrierValid(carrierValid),
   .carrierEvm(carrierEvm), .symbolEnd(symbolEnd));
`default_nettype wire

// ### tb/rxevm_stats_test.sv
`timescale 1ns/1ps
`default_nettype none
module rxevm_stats_test;
   logic        core_clk     = 1'b0;
   logic        nrst         = 1'b0;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [17:0] paddr        = 18'h0;
   logic [31:0] pwdata       = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxStart      = 1'b0;
   logic        rxEnd        = 1'b0;
   logic        carrierValid = 1'b0;
   logic        symbolEnd    = 1'b0;
   logic [15:0] carrierEvm   = 16'h0;
   logic [3:0]  pstrb        = 4'hF;
   // Own control, status and payload count words
   localparam logic [17:0] CTRL_A = {rxevm_pkg::IDX_CTRL, 2'b00};
   localparam logic [17:0] STAT_A = {rxevm_pkg::IDX_STATUS, 2'b00};
   localparam logic [17:0] PCNT_A = {rxevm_pkg::IDX_PAY_CNT, 2'b00};
   int          errors       = 0;
   int          totalChecks  = 0;
   int          cycles       = 0;
   logic [17:0] regs [4]     = '{{rxevm_pkg::IDX_HDR_PEAK, 2'b00}, {rxevm_pkg::IDX_PAY_PEAK, 2'b00},
                                 {rxevm_pkg::IDX_HDR_SUM, 2'b00}, {rxevm_pkg::IDX_PAY_SUM, 2'b00}};
   // Message one: peaks 2000/3F80, sums max(1C34,2100), max(1000,3F81,0200)
   logic [31:0] expA [4]     = '{32'h00002000, 32'h00003F80, 32'h02100000, 32'h03F81000};
   // Message two: peaks 0030/0040, sums max(0030,0031), 0042
   logic [31:0] expB [4]     = '{32'h00000030, 32'h00000040, 32'h00031000, 32'h00042000};

   always #50 core_clk = ~core_clk;

   rxevm_stats u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxStart(rxStart), .rxEnd(rxEnd),
      .carrierValid(carrierValid), .carrierEvm(carrierEvm), .symbolEnd(symbolEnd));

   task automatic close_out();
      if (errors == 0 && totalChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // APB transfer; the idle edge at the end stops psel being set twice in one step
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [17:0] a, input logic [31:0] exp, input logic eExp,
                     output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
      check({31'h0, e}, {31'h0, eExp});
   endtask

   // Two carriers per symbol, the second one closes it
   task automatic sym(input logic [15:0] a, input logic [15:0] b);
      carrierValid <= 1'b1;
      carrierEvm <= a;
      @(posedge core_clk);
      carrierEvm <= b;
      symbolEnd <= 1'b1;
      @(posedge core_clk);
      carrierValid <= 1'b0;
      symbolEnd <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic pulse(input logic start);
      rxStart <= start;
      rxEnd <= !start;
      @(posedge core_clk);
      rxStart <= 1'b0;
      rxEnd <= 1'b0;
   endtask

   // Hang guard, well above the under two hundred cycles the sequence needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      logic [31:0] r;
      logic        e;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) rd(regs[i], 32'h0, 1'b0, r);
      rd({16'hFE3C, 2'b00}, 32'h0, 1'b1, r);
      pulse(1'b1);
      sym(16'h1234, 16'h0A00);
      sym(16'h2000, 16'h0100);
      sym(16'h0800, 16'h0800);
      sym(16'h3F80, 16'h0001);
      sym(16'h0100, 16'h0100);
      pulse(1'b0);
      for (int i = 0; i < 4; i++) rd(regs[i], expA[i], 1'b0, r);
      rd(PCNT_A, 32'h3, 1'b0, r);
      // 3F80 splits into 31 percent and fraction 180
      rd(regs[1], expA[1], 1'b0, r);
      check({25'h0, r[15:9]}, 32'h1F);
      check({23'h0, r[8:0]}, 32'h180);
      apb(1'b1, regs[2], 32'hFFFFFFFF, r, e);
      check({31'h0, e}, 32'h0);
      apb(1'b1, regs[0], 32'hFFFFFFFF, r, e);
      check({31'h0, e}, 32'h0);
      for (int i = 0; i < 4; i++) rd(regs[i], expA[i], 1'b0, r);
      pulse(1'b1);
      rd(regs[0], 32'h0, 1'b0, r);
      rd(regs[3], 32'h0, 1'b0, r);
      sym(16'h0010, 16'h0020);
      sym(16'h0030, 16'h0001);
      sym(16'h0040, 16'h0002);
      pulse(1'b0);
      for (int i = 0; i < 4; i++) rd(regs[i], expB[i], 1'b0, r);
      // Soft clear empties the trackers; status keeps idle and two header symbols
      apb(1'b1, CTRL_A, 32'h3, r, e);
      rd(regs[1], 32'h0, 1'b0, r);
      rd(regs[2], 32'h0, 1'b0, r);
      rd(STAT_A, 32'h21, 1'b0, r);
      // A control write without byte strobe 0 is ignored
      pstrb <= 4'hE;
      apb(1'b1, CTRL_A, 32'h0, r, e);
      pstrb <= 4'hF;
      rd(CTRL_A, 32'h1, 1'b0, r);
      // Capture off: trackers stay clear while the payload count still runs
      apb(1'b1, CTRL_A, 32'h0, r, e);
      rd(CTRL_A, 32'h0, 1'b0, r);
      pulse(1'b1);
      sym(16'h0100, 16'h0100);
      sym(16'h0100, 16'h0100);
      sym(16'h0200, 16'h0200);
      pulse(1'b0);
      rd(regs[0], 32'h0, 1'b0, r);
      rd(regs[3], 32'h0, 1'b0, r);
      rd(PCNT_A, 32'h1, 1'b0, r);
      // Mid-run reset brings every word back to its reset value
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) rd(regs[i], 32'h0, 1'b0, r);
      rd(CTRL_A, 32'h1, 1'b0, r);
      rd(STAT_A, 32'h1, 1'b0, r);
      close_out();
   end
endmodule
`default_nettype wire
